/* ddci_control.sv */
`timescale 1ns/1ps
module ddci_control
   import ddci_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic      [31:0]         hrdata,
   output logic                     hresp,
   input  wire logic                integrate_side_select,
   input  wire logic                gain_select_bit0,
   input  wire logic                gain_select_bit1,
   input  wire logic                gain_select_bit2,
   input  wire logic                shift_clock,
   input  wire logic                shift_enable_n,
   input  wire logic                cascade_in,
   input  wire logic [RESULT_W-1:0] adc_code,
   output logic                     serial_out,
   output logic                     serial_out_en,
   output logic                     result_ready_n,
   output ddci_switch_type          switches,
   output logic      [2:0]          cap_code,
   output logic                     ext_cap_en,
   output logic                     irq
);
   // pin synchronisation: select, shift pins, cascade and range code; the transmit
   // enable stages reset high, its idle level, so no false enable follows reset
   logic [6:0] pins_s;
   logic       sel_s, sclk_s, sen_n_s, casc_s;
   logic [2:0] gain_s;
   ddci_sync #(.W(7), .RST(7'h10)) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({integrate_side_select, shift_clock, shift_enable_n, cascade_in,
                gain_select_bit2, gain_select_bit1, gain_select_bit0}),
      .q     (pins_s)
   );
   assign sel_s   = pins_s[6];
   assign sclk_s  = pins_s[5];
   assign sen_n_s = pins_s[4];
   assign casc_s  = pins_s[3];
   assign gain_s  = pins_s[2:0];
   // bus decode used by both the read and the write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit
   // bus slave: one wait state so read data can come from a register
   ddci_req_type req_q, req_d;
   logic         pend_q, pend_d;
   logic         hready_d;
   logic [31:0]  rdata_d;
   logic         accept;
   logic         wr_en;
   // software state
   logic             run_q, run_d;
   logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, events;
   logic             irq_d;
   logic [RESULT_W-1:0] last1_q, last1_d, last2_q, last2_d;
   // sequencer state
   ddci_state_type   state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             side_q, side_d;
   logic             sel_prev_q;
   ddci_switch_type  sw_d;
   logic [RESULT_W-1:0] res1_q, res1_d;
   logic [2:0]       cap_d;
   logic             ext_d;
   logic             load;
   logic             rise, fall;
   assign accept = hsel & hready & htrans[1];
   assign wr_en  = pend_q & req_q.wr;
   always_comb
   begin
      pend_d   = pend_q;
      req_d    = req_q;
      hready_d = hreadyout;
      rdata_d  = hrdata;
      if (pend_q)
      begin
         pend_d   = 1'b0;
         hready_d = 1'b1;
         rdata_d  = 32'h0000_0000;      // unmapped reads give zero
         if (hit(req_q.addr, ADDR_CTRL))
            rdata_d[CTRL_RUN_BIT] = run_q;
         if (hit(req_q.addr, ADDR_STATUS))
         begin
            rdata_d[STS_STATE_LSB +: 5] = state_q;
            rdata_d[STS_SIDE_BIT]       = side_q;
            rdata_d[STS_READY_BIT]      = result_ready_n;
            rdata_d[STS_RANGE_LSB +: 3] = cap_code;
         end
         if (hit(req_q.addr, ADDR_IRQ_STAT))
            rdata_d[IRQ_W-1:0] = stat_q;
         if (hit(req_q.addr, ADDR_IRQ_MASK))
            rdata_d[IRQ_W-1:0] = mask_q;
         if (hit(req_q.addr, ADDR_RESULT1))
            rdata_d[RESULT_W-1:0] = last1_q;
         if (hit(req_q.addr, ADDR_RESULT2))
            rdata_d[RESULT_W-1:0] = last2_q;
      end
      else if (accept)
      begin
         pend_d   = 1'b1;
         hready_d = 1'b0;
         req_d    = '{wr: hwrite, addr: haddr[7:0]};
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_q    <= 1'b0;
         req_q     <= '0;
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'b0;
      end
      else
      begin
         pend_q    <= pend_d;
         req_q     <= req_d;
         hreadyout <= hready_d;
         hrdata    <= rdata_d;
         hresp     <= 1'b0;               // always OKAY
      end
   end

   // control, interrupt status and mask; a new event beats its clear
   assign events[IRQ_LOAD_BIT] = load;
   assign events[IRQ_EDGE_BIT] = rise | fall;
   assign events[IRQ_OVR_BIT]  = load & ~result_ready_n;   // previous result never shifted out
   always_comb
   begin
      run_d   = run_q;
      mask_d  = mask_q;
      stat_d  = stat_q;
      last1_d = last1_q;
      last2_d = last2_q;
      if (wr_en && hit(req_q.addr, ADDR_CTRL))
         run_d = hwdata[CTRL_RUN_BIT];
      if (wr_en && hit(req_q.addr, ADDR_IRQ_MASK))
         mask_d = hwdata[IRQ_W-1:0];
      if (wr_en && hit(req_q.addr, ADDR_IRQ_STAT))
         stat_d = stat_q & ~hwdata[IRQ_W-1:0];
      stat_d = stat_d | events;
      if (load)
      begin
         last1_d = res1_q;
         last2_d = adc_code;
      end
      irq_d = |(stat_d & mask_d);
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         run_q   <= CTRL_RUN_RST;
         mask_q  <= IRQ_MASK_RST;
         stat_q  <= '0;
         irq     <= 1'b0;
         last1_q <= '0;
         last2_q <= '0;
      end
      else
      begin
         run_q   <= run_d;
         mask_q  <= mask_d;
         stat_q  <= stat_d;
         irq     <= irq_d;
         last1_q <= last1_d;
         last2_q <= last2_d;
      end
   end

   // sequencer: edges of the sampled select line steer the front end
   assign rise = sel_s & ~sel_prev_q;
   assign fall = ~sel_s & sel_prev_q;
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q + CNT_W'(1);
      side_d  = side_q;
      sw_d    = switches;
      res1_d  = res1_q;
      load    = 1'b0;
      // same code to both integrators; zero picks external parts
      cap_d   = gain_s;
      ext_d   = (gain_s == 3'h0);
      case (state_q)
         ST_CONV1:
            if (cnt_q == INTEGRATE_SIDE_SELECT_LAST)
            begin
               res1_d       = adc_code;
               state_d      = ST_CONV2;
               cnt_d        = '0;
               sw_d.mux_sel = {side_q, 1'b1};
            end
         ST_CONV2:
            if (cnt_q == INTEGRATE_SIDE_SELECT_LAST)
            begin
               load    = 1'b1;
               state_d = ST_RESET;
               cnt_d   = '0;
               sw_d.ref_a = ~side_q;
               sw_d.ref_b = side_q;
            end
         ST_RESET:
            if (cnt_q == RESET_LAST)
            begin
               state_d    = ST_WAIT;
               cnt_d      = '0;
               sw_d.ref_a = 1'b0;
               sw_d.ref_b = 1'b0;
            end
         ST_IDLE, ST_WAIT:
            cnt_d = cnt_q;
         default:
         begin
            state_d = ST_IDLE;
            cnt_d   = '0;
         end
      endcase
      // with run set, an edge restarts the cycle, even if the last one was unfinished
      if (rise || fall)
      begin
         sw_d.int_a = rise;
         sw_d.int_b = fall;
         sw_d.ref_a = 1'b0;
         sw_d.ref_b = 1'b0;
         if (run_q)
         begin
            side_d       = rise;
            state_d      = ST_CONV1;
            cnt_d        = '0;
            sw_d.mux_sel = {rise, 1'b0};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         side_q     <= 1'b0;
         sel_prev_q <= 1'b0;
         switches   <= '0;
         res1_q     <= '0;
         cap_code   <= 3'h0;
         ext_cap_en <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         side_q     <= side_d;
         sel_prev_q <= sel_s;
         switches   <= sw_d;
         res1_q     <= res1_d;
         cap_code   <= cap_d;
         ext_cap_en <= ext_d;
      end
   end
   // serial readout on its own sampled clock
   ddci_shifter u_shift (
      .clk              (hclk),
      .rst_n            (hresetn),
      .load             (load),
      .load_data        ({res1_q, adc_code}),
      .shift_clock_s    (sclk_s),
      .shift_enable_n_s (sen_n_s),
      .cascade_s        (casc_s),
      .serial_out       (serial_out),
      .serial_out_en    (serial_out_en),
      .result_ready_n   (result_ready_n)
   );
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_integrate_side_select_end;
      state_q == ST_CONV2 && cnt_q == INTEGRATE_SIDE_SELECT_LAST && !rise && !fall;
   endsequence
   sequence s_reset_end;
      state_q == ST_RESET && cnt_q == RESET_LAST && !rise && !fall;
   endsequence
   a_rise_side_a: assert property (rise && run_q
      |=> switches.int_a && !switches.int_b && side_q && state_q == ST_CONV1)
      else $error("rising select did not start side A");
   a_fall_side_b: assert property (fall && run_q
      |=> switches.int_b && !switches.int_a && !side_q && state_q == ST_CONV1)
      else $error("falling select did not swap to side B");
   a_mux_follows: assert property (state_q inside {ST_CONV1, ST_CONV2}
      |-> switches.mux_sel[1] == side_q)
      else $error("converter not on the idle side");
   a_integrate_side_select_count: assert property (state_q inside {ST_CONV1, ST_CONV2}
      |-> cnt_q <= INTEGRATE_SIDE_SELECT_LAST)
      else $error("conversion overran its count");
   a_load_ready: assert property (s_integrate_side_select_end |=> ##1 !result_ready_n)
      else $error("ready not shown after load");
   a_reset_ref: assert property (s_integrate_side_select_end
      |=> state_q == ST_RESET && (side_q ? switches.ref_b : switches.ref_a))
      else $error("reference not applied in reset");
   a_reset_wait: assert property (s_reset_end
      |=> state_q == ST_WAIT && !switches.ref_a && !switches.ref_b)
      else $error("wait not entered with reference off");
   // the first edge out of reset still shows the reset values, so it is skipped
   a_range_follow: assert property (hresetn
      |=> cap_code == $past(gain_s) && ext_cap_en == ($past(gain_s) == 3'h0))
      else $error("range code not applied");
   a_sel_edge: assert property ($rose(sel_s) |=> switches.int_a && !switches.int_b)
      else $error("select edge missed");
endmodule : ddci_control

/* ddci_pkg.sv */
package ddci_pkg;

   // result, shift register and counter sizes
   localparam int RESULT_W = 20;
   localparam int SHIFT_W  = 2 * RESULT_W;
   localparam int CNT_W    = 12;

   // timing: the conversion count follows the nominal system clock
   localparam int NOM_CLK_MHZ   = 10;
   localparam int HCLK_MHZ      = 20;
   localparam int INTEGRATE_SIDE_SELECT_TIME_NS  = 220000;
   localparam int INTEGRATE_SIDE_SELECT_CYCLES   = (INTEGRATE_SIDE_SELECT_TIME_NS * NOM_CLK_MHZ + 999) / 1000;
   localparam int RESET_TIME_NS = 5000;
   localparam int RESET_CYCLES  = (RESET_TIME_NS * HCLK_MHZ + 999) / 1000;
   localparam logic [CNT_W-1:0] INTEGRATE_SIDE_SELECT_LAST  = CNT_W'(INTEGRATE_SIDE_SELECT_CYCLES - 1);
   localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYCLES - 1);

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_RESULT1  = 8'h10;
   localparam logic [7:0] ADDR_RESULT2  = 8'h14;

   // field positions
   localparam int CTRL_RUN_BIT  = 0;
   localparam int STS_STATE_LSB = 0;
   localparam int STS_SIDE_BIT  = 8;
   localparam int STS_READY_BIT = 12;
   localparam int STS_RANGE_LSB = 16;
   localparam int IRQ_LOAD_BIT  = 0;
   localparam int IRQ_EDGE_BIT  = 1;
   localparam int IRQ_OVR_BIT   = 2;
   localparam int IRQ_W         = 3;

   // reset values
   localparam logic             CTRL_RUN_RST = 1'h1;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // sequencer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_CONV1 = 5'h02,
      ST_CONV2 = 5'h04,
      ST_RESET = 5'h08,
      ST_WAIT  = 5'h10
   } ddci_state_type;

   // front end switch controls shared by both inputs
   typedef struct packed {
      logic       int_a;
      logic       int_b;
      logic       ref_a;
      logic       ref_b;
      logic [1:0] mux_sel;
   } ddci_switch_type;

   // captured bus address phase
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } ddci_req_type;

endpackage : ddci_pkg

/* ddci_sync.sv */
`timescale 1ns/1ps
// two flop synchroniser for pins from outside the clock domain
module ddci_sync
   import ddci_pkg::*;
#(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second; both reset to the pins' idle levels
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RST;
         q      <= RST;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : ddci_sync

/* ddci_shifter.sv */
`timescale 1ns/1ps
// serial result register, shifted by the sampled shift clock
module ddci_shifter
   import ddci_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               load,
   input  wire logic [SHIFT_W-1:0] load_data,
   input  wire logic               shift_clock_s,
   input  wire logic               shift_enable_n_s,
   input  wire logic               cascade_s,
   output logic                    serial_out,
   output logic                    serial_out_en,
   output logic                    result_ready_n
);

   logic [SHIFT_W-1:0] sreg_q, sreg_d;
   logic               sclk_prev_q;
   logic               ready_n_d;
   logic               oe_d;
   logic               shift_edge;

   // the shift clock is sampled here, so readout runs at its own rate
   assign shift_edge = shift_clock_s & ~sclk_prev_q & ~shift_enable_n_s;

   always_comb
   begin
      sreg_d    = sreg_q;
      ready_n_d = result_ready_n;
      oe_d      = ~shift_enable_n_s;
      if (shift_edge)
      begin
         sreg_d    = {sreg_q[SHIFT_W-2:0], cascade_s};
         ready_n_d = 1'b1;
      end
      // a new result wins over a shift in the same cycle
      if (load)
      begin
         sreg_d    = load_data;
         ready_n_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sreg_q         <= '0;
         sclk_prev_q    <= 1'b0;
         result_ready_n <= 1'b1;
         serial_out_en  <= 1'b0;
      end
      else
      begin
         sreg_q         <= sreg_d;
         sclk_prev_q    <= shift_clock_s;
         result_ready_n <= ready_n_d;
         serial_out_en  <= oe_d;
      end
   end

   assign serial_out = sreg_q[SHIFT_W-1]; // straight from the register

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_hiz_when_off: assert property (shift_enable_n_s |=> !serial_out_en)
      else $error("serial output driven while shifting disabled");
   a_hold_when_off: assert property (shift_enable_n_s && !load |=> $stable(sreg_q))
      else $error("shift register moved while disabled");
   a_shift_step: assert property (shift_edge && !load
      |=> sreg_q == {$past(sreg_q[SHIFT_W-2:0]), $past(cascade_s)})
      else $error("shift step wrong");

endmodule : ddci_shifter

/* ddci_host_model.sv */
`timescale 1ns/1ps
// host side: moves the select pin on the system clock and reads the serial chain
module ddci_host_model
   import ddci_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        sel_req,
   input  wire logic        chain,
   input  wire logic        go,
   input  wire logic        serial_out,
   input  wire logic        serial_out_en,
   output logic             integrate_side_select = 1'b0,
   output logic             shift_clock = 1'b0,
   output logic             shift_enable_n = 1'b1,
   output logic             cascade_in = 1'b0,
   output logic      [47:0] word = 48'h0,
   output logic             done = 1'b0
);
   // select and cascade move just after a rising system clock edge
   always @(posedge hclk)
   begin
      integrate_side_select <= sel_req;
      cascade_in            <= chain;
   end

   // one frame: 40 result bits then 8 cascade bits; the link clock stands still outside it
   always @(posedge go)
   begin
      shift_enable_n <= 1'b0;
      #400;
      for (int i = 47; i >= 0; i--)
      begin
         // a released output reads inverted so it can never pass for data
         word[i]     <= serial_out_en ? serial_out : ~serial_out;
         shift_clock <= 1'b1;
         #200;
         shift_clock <= 1'b0;
         #200;
      end
      shift_enable_n <= 1'b1;
      @(posedge hclk) done <= 1'b1;
      @(posedge hclk) done <= 1'b0;
   end
endmodule : ddci_host_model

/* ddci_control_tb.sv */
`timescale 1ns/1ps
// bench: drivers note expected values, a monitor compares them as results appear
module ddci_control_tb
   import ddci_pkg::*;
   ();
   logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic                rd_ph = 1'b0, sel_req = 1'b0, chain = 1'b0, go = 1'b0;
   logic                hreadyout, hresp, irq, done, isel, sclk, sen_n, casc;
   logic                sout, sout_en, rdy_n, ext_cap_en;
   logic [1:0]          htrans = 2'h0;
   logic [2:0]          hsize = 3'h2, gain = 3'h0;
   logic [2:0]          cap_code;
   logic [31:0]         haddr = 32'h0, hwdata = 32'h0;
   logic [31:0]         hrdata;
   logic [RESULT_W-1:0] adc = 20'h0, v1, v2, v3, v4;
   logic [47:0]         word;
   ddci_switch_type     switches;
   int                  fail_count = 0, comparisons = 0, cyc = 0, n;
   logic [31:0]         exp_q[$];
   logic [47:0]         exp_s[$];

   ddci_control ddci_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .integrate_side_select(isel),
      .gain_select_bit0(gain[0]), .gain_select_bit1(gain[1]), .gain_select_bit2(gain[2]),
      .shift_clock(sclk), .shift_enable_n(sen_n), .cascade_in(casc), .adc_code(adc),
      .serial_out(sout), .serial_out_en(sout_en), .result_ready_n(rdy_n),
      .switches(switches), .cap_code(cap_code), .ext_cap_en(ext_cap_en), .irq(irq));

   ddci_host_model ddci_host_model_i (.hclk(hclk), .sel_req(sel_req), .chain(chain),
      .go(go), .serial_out(sout), .serial_out_en(sout_en), .integrate_side_select(isel),
      .shift_clock(sclk), .shift_enable_n(sen_n), .cascade_in(casc), .word(word),
      .done(done));

   initial
   begin
      forever #25 hclk = ~hclk;
   end

   // one compare; a mismatch prints time and both values
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   // single word transfer: address held until taken, data held until answered
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph  <= ~w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph  <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(a, 1'b0, 32'h0);
   endtask : rd

   // completed reads and frames each take the oldest note; the cycle cap cuts a hang
   always @(posedge hclk)
   begin
      cyc++;
      if (rd_ph && hreadyout === 1'b1)
      begin
         chk({16'h0, hrdata}, {16'h0, exp_q.pop_front()});
         chk({47'h0, hresp}, 48'h0);
      end
      if (done === 1'b1)
         chk(word, exp_s.pop_front());
      if (cyc == 16000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   initial
   begin
      void'($urandom(32'h4A647C20));
      v1 = RESULT_W'($urandom);
      v2 = RESULT_W'($urandom);
      v3 = RESULT_W'($urandom);
      v4 = RESULT_W'($urandom);
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      // every range code, ending on 7
      for (int c = 0; c < 8; c++)
      begin
         @(posedge hclk);
         gain <= 3'(c);
         repeat (5) @(posedge hclk);
         chk({45'h0, cap_code}, 48'(c));
         chk({47'h0, ext_cap_en}, {47'h0, c == 0});
      end
      rd(ADDR_CTRL, 32'h1);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_STATUS, 32'h0007_1001);
      xfer(8'h20, 1'b1, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      // rising select: side A integrates, side B goes to the converter
      adc     <= v1;
      sel_req <= 1'b1;
      repeat (6) @(posedge hclk);
      chk({42'h0, switches}, 48'h22);
      rd(ADDR_IRQ_STAT, 32'h2);
      xfer(ADDR_IRQ_MASK, 1'b1, 32'h2);
      repeat (2) @(posedge hclk);
      chk({47'h0, irq}, 48'h1);
      xfer(ADDR_IRQ_STAT, 1'b1, 32'h2);
      repeat (2) @(posedge hclk);
      chk({47'h0, irq}, 48'h0);
      xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
      for (n = 0; n < 2400 && switches.mux_sel[0] !== 1'b1; n++) @(posedge hclk);
      adc <= v2;
      for (n = 0; n < 2400 && rdy_n !== 1'b0; n++) @(posedge hclk);
      chk({47'h0, n >= 2195 && n <= 2205}, 48'h1);
      repeat (2) @(posedge hclk);
      chk({47'h0, irq}, 48'h1);
      chk({46'h0, switches.ref_a, switches.ref_b}, 48'h1);
      rd(ADDR_RESULT1, {12'h0, v1});
      rd(ADDR_RESULT2, {12'h0, v2});
      repeat (110) @(posedge hclk);
      chk({46'h0, switches.ref_a, switches.ref_b}, 48'h0);
      // falling select with the result not shifted out: swap sides and overrun
      sel_req <= 1'b0;
      adc     <= v3;
      repeat (6) @(posedge hclk);
      chk({42'h0, switches}, 48'h10);
      for (n = 0; n < 2400 && switches.mux_sel[0] !== 1'b1; n++) @(posedge hclk);
      adc <= v4;
      for (n = 0; n < 2400 && switches.ref_a !== 1'b1; n++) @(posedge hclk);
      rd(ADDR_IRQ_STAT, 32'h7);
      // chained frame: result MSB first, then the cascade input's ones
      exp_s.push_back({v3, v4, 8'hFF});
      chain <= 1'b1;
      repeat (4) @(posedge hclk);
      go <= 1'b1;
      for (n = 0; n < 900 && done !== 1'b1; n++) @(posedge hclk);
      repeat (5) @(posedge hclk);
      chk({46'h0, sout_en, rdy_n}, 48'h1);
      // sequencing off: a select edge moves the input switches but starts nothing
      xfer(ADDR_CTRL, 1'b1, 32'h0);
      sel_req <= 1'b1;
      repeat (6) @(posedge hclk);
      chk({42'h0, switches}, 48'h21);
      rd(ADDR_STATUS, 32'h0007_1010);
      // let the monitor take the last note, then no read or frame may be missing
      @(posedge hclk);
      chk(48'(exp_q.size() + exp_s.size()), 48'h0);
      give_verdict();
   end
endmodule : ddci_control_tb
